// File: rtl/scs_sync_core.v
// Contract
// - no backward step while error under 4s
// - pins or virtual pulse as minute source
// - selector: none, input one, input two, virtual
// - pulse edge rounds time to nearest minute
// - no input filter, polarity selects edge
// - each sync message updates source indicator
// - no sync for 1.5 min: internal
// - indicator internal after timeout, 90s used
// - distinct codes per sync source
// - 16-bit message counter wraps around
// - signed deviation clamped to 32767 ms
// - filtered deviation within 125 ms applied
// - constant offset added to source time
// - positive offset compensates lagging source
// - one ms correction per adjust interval
// - drift sign picks retard or advance
// - external sync learns interval and sign
// - zone offset hours for network time
// - summer time enable for network time
// - deviation under 4 s removed gradually, 4 s or more stepped
// - auto-adjust step exactly one ms
`timescale 1ns/1ns
`default_nettype none
`include "scs_regs.vh"

module scs_sync_core #(
  parameter TICK_CYC = `SCS_TICK_CYC
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // minute pulse pins
  input wire pulse_input_one,
  input wire pulse_input_two,
  // time and state
  output reg [26:0] time_ms,
  output reg [3:0] active_sync_source
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // saturate to +-lim
  function signed [33:0] scs_sat;
    input signed [33:0] x;
    input signed [33:0] lim;
    begin
      if (x > lim)
        scs_sat = lim;
      else if (x < -lim)
        scs_sat = -lim;
      else
        scs_sat = x;
    end
  endfunction

  // wrap into one day
  function [33:0] scs_wrap;
    input signed [33:0] x;
    begin
      if (x < 0)
        scs_wrap = x + `SCS_DAY_MS;
      else if (x >= `SCS_DAY_MS)
        scs_wrap = x - `SCS_DAY_MS;
      else
        scs_wrap = x;
    end
  endfunction

  // full-width constants, then cut to the counter widths on purpose
  localparam [31:0] TICK_FULL = TICK_CYC - 1;
  localparam [15:0] TICK_LAST = TICK_FULL[15:0];
  localparam [31:0] MS_FULL = `SCS_MS_PER_S - 1;
  localparam [9:0] MS_LAST = MS_FULL[9:0];
  localparam [31:0] TMO_FULL = `SCS_TMO_S;
  localparam [6:0] TMO_S = TMO_FULL[6:0];

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [15:0] pre_r; // cycle prescaler
  reg [9:0] msec_r; // ms within second
  reg [6:0] idle_r; // seconds since sync
  reg [15:0] cnt_r; // message counter
  reg signed [15:0] dev_r; // latest deviation
  reg signed [7:0] fdev_r; // filtered deviation
  reg signed [7:0] slew_r; // ms still to remove
  reg [1:0] sel_r; // minute pulse select
  reg [1:0] pol_r; // input inversion
  reg dst_r; // summer time enable
  reg drift_r; // 1 lead, 0 lag
  reg [3:0] code_r; // next message source
  reg signed [31:0] offs_r; // source offset ms
  reg signed [11:0] zone_r; // zone, 0.01 h
  reg [9:0] intv_r; // adjust interval s
  reg [9:0] acnt_r; // seconds in interval
  reg apend_r; // adjust step due
  reg [1:0] s1_r; // first sync stage
  reg [1:0] s2_r; // second sync stage
  reg [1:0] lv_r; // previous level

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire setup = psel & ~penable;
  reg hit;

  // known offsets
  always @* begin
    case (paddr)
      `SCS_A_CTRL, `SCS_A_TIME, `SCS_A_SYNC,
      `SCS_A_CODE, `SCS_A_OFFS, `SCS_A_ZONE,
      `SCS_A_INTV, `SCS_A_STAT, `SCS_A_DEV: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  // ----------------------------------------
  // events
  // ----------------------------------------
  wire tick = (pre_r == TICK_LAST);
  wire sec = tick & (msec_r == MS_LAST);
  // leading edge after polarity, no filter
  wire [1:0] lvl = s2_r ^ pol_r;
  wire [1:0] rise = lvl & ~lv_r;
  wire vpul = wr & (paddr == `SCS_A_CTRL) & pwdata[`SCS_C_VPULSE];
  reg pev;

  // selected minute pulse
  always @* begin
    case (sel_r)
      `SCS_SEL_ONE: pev = rise[0];
      `SCS_SEL_TWO: pev = rise[1];
      `SCS_SEL_VIRT: pev = vpul;
      default: pev = 1'b0;
    endcase
  end

  wire mev = wr & (paddr == `SCS_A_SYNC);
  wire ev = pev | mev;

  // ----------------------------------------
  // deviation math
  // ----------------------------------------
  reg signed [33:0] now;
  reg signed [33:0] adj;
  reg signed [33:0] dfull;
  reg signed [33:0] rem;
  reg signed [33:0] dclp;
  reg signed [33:0] favg;
  reg signed [33:0] fclp;
  reg [33:0] tgt;
  reg big;

  always @* begin
    now = {7'h00, time_ms};
    rem = now % `SCS_MIN_MS;
    // source time with offset, plus zone and summer hour for network time only
    adj = {7'h00, pwdata[26:0]} + {{2{offs_r[31]}}, offs_r};
    if (code_r == `SCS_SRC_NTP) begin
      adj = adj + {{22{zone_r[11]}}, zone_r} * `SCS_ZONE_MS;
      if (dst_r)
        adj = adj + `SCS_HOUR_MS;
    end
    adj = scs_wrap(adj);
    // positive: clock ahead of source
    if (pev) begin
      if (rem < `SCS_HALF_MIN_MS)
        dfull = rem;
      else
        dfull = rem - `SCS_MIN_MS;
    end else begin
      dfull = now - adj;
      // constants made signed, else a negative deviation compares as huge
      if (dfull > $signed(`SCS_HALF_DAY_MS))
        dfull = dfull - `SCS_DAY_MS;
      else if (dfull < -$signed(`SCS_HALF_DAY_MS))
        dfull = dfull + `SCS_DAY_MS;
    end
    dclp = scs_sat(dfull, `SCS_DEV_LIM);
    // mean of this and last deviation, arithmetic shift keeps the sign
    favg = (dclp + $signed({{18{dev_r[15]}}, dev_r})) >>> 1;
    fclp = scs_sat(favg, `SCS_FDEV_LIM);
    big = (dfull >= $signed(`SCS_STEP_MS)) | (dfull <= -$signed(`SCS_STEP_MS));
    tgt = scs_wrap(now - dfull);
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two stages, then edge memory
  always @(posedge clk) begin
    if (!nrst) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      lv_r <= 2'h0;
    end else begin
      s1_r <= {pulse_input_two, pulse_input_one};
      s2_r <= s1_r;
      lv_r <= lvl;
    end
  end

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  reg [1:0] step; // ms added this tick

  // pick increment: 0 slows, 2 speeds
  always @* begin
    if (slew_r > 0)
      step = 2'h0;
    else if (slew_r < 0)
      step = 2'h2;
    else if (apend_r)
      step = drift_r ? 2'h0 : 2'h2;
    else
      step = 2'h1;
  end

  wire [33:0] tinc = scs_wrap(now + {32'h0, step});

  // prescaler and time counter
  always @(posedge clk) begin
    if (!nrst) begin
      pre_r <= 16'h0000;
      msec_r <= 10'h000;
      time_ms <= 27'h0000000;
    end else begin
      pre_r <= tick ? 16'h0000 : pre_r + 16'h0001;
      if (tick)
        msec_r <= (msec_r == MS_LAST) ? 10'h000 : msec_r + 10'h001;
      if (wr & (paddr == `SCS_A_TIME))
        time_ms <= (pwdata[26:0] < `SCS_DAY_MS) ? pwdata[26:0] : 27'h0000000;
      else if (ev & big)
        time_ms <= tgt[26:0];
      else if (tick)
        time_ms <= tinc[26:0];
    end
  end

  // ----------------------------------------
  // correction and auto-adjust
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      slew_r <= 8'h00;
      acnt_r <= 10'h000;
      apend_r <= 1'b0;
    end else begin
      // new sync sets remaining correction
      if (ev)
        slew_r <= big ? 8'h00 : fclp[7:0];
      else if (tick & (slew_r > 0))
        slew_r <= slew_r - 8'sh01;
      else if (tick & (slew_r < 0))
        slew_r <= slew_r + 8'sh01;
      // one step per interval
      if (intv_r == 10'h000) begin
        acnt_r <= 10'h000;
        apend_r <= 1'b0;
      end else begin
        if (sec) begin
          if (acnt_r + 10'h001 >= intv_r) begin
            acnt_r <= 10'h000;
            apend_r <= 1'b1;
          end else begin
            acnt_r <= acnt_r + 10'h001;
          end
        end else if (tick & (slew_r == 0)) begin
          apend_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // source, counter, deviations
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      active_sync_source <= `SCS_SRC_INT;
      idle_r <= 7'h00;
      cnt_r <= 16'h0000;
      dev_r <= 16'h0000;
      fdev_r <= 8'h00;
    end else begin
      if (ev) begin
        active_sync_source <= pev ? `SCS_SRC_DI : code_r;
        idle_r <= 7'h00;
        cnt_r <= cnt_r + 16'h0001;
        dev_r <= dclp[15:0];
        fdev_r <= big ? 8'h00 : fclp[7:0];
      end else if (sec) begin
        if (idle_r == TMO_S)
          active_sync_source <= `SCS_SRC_INT;
        else
          idle_r <= idle_r + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // settings and learning
  // ----------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      sel_r <= `SCS_SEL_NONE;
      pol_r <= 2'h0;
      dst_r <= 1'b0;
      drift_r <= 1'b0;
      code_r <= `SCS_SRC_NTP;
      offs_r <= 32'h00000000;
      zone_r <= 12'h000;
      intv_r <= 10'h000;
    end else begin
      if (wr & (paddr == `SCS_A_CTRL)) begin
        sel_r <= pwdata[`SCS_C_SEL];
        pol_r <= pwdata[`SCS_C_POL2:`SCS_C_POL1];
        dst_r <= pwdata[`SCS_C_DST];
      end
      if (wr & (paddr == `SCS_A_CODE))
        code_r <= pwdata[3:0];
      if (wr & (paddr == `SCS_A_OFFS))
        offs_r <= pwdata;
      if (wr & (paddr == `SCS_A_ZONE))
        zone_r <= pwdata[11:0];
      // learning overrides software values
      if (ev & ~big & (fclp != 0)) begin
        if (intv_r == 10'h000) begin
          intv_r <= `SCS_INTV_MAX;
          drift_r <= (fclp > 0);
        end else if (drift_r == (fclp > 0)) begin
          intv_r <= (intv_r > 10'h001) ? {1'b0, intv_r[9:1]} : 10'h001;
        end else begin
          intv_r <= (intv_r >= `SCS_INTV_HALF) ? `SCS_INTV_MAX : {intv_r[8:0], 1'b0};
        end
      end else if (wr & (paddr == `SCS_A_INTV)) begin
        intv_r <= (pwdata[9:0] > `SCS_INTV_MAX) ? `SCS_INTV_MAX : pwdata[9:0];
      end else if (wr & (paddr == `SCS_A_CTRL)) begin
        drift_r <= pwdata[`SCS_C_DRIFT];
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // captured in setup, valid in access
  always @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      case (paddr)
        `SCS_A_CTRL: prdata <= {25'h0, drift_r, dst_r, 1'b0, pol_r, sel_r};
        `SCS_A_TIME: prdata <= {5'h00, time_ms};
        `SCS_A_CODE: prdata <= {28'h0, code_r};
        `SCS_A_OFFS: prdata <= offs_r;
        `SCS_A_ZONE: prdata <= {{20{zone_r[11]}}, zone_r};
        `SCS_A_INTV: prdata <= {22'h0, intv_r};
        `SCS_A_STAT: prdata <= {cnt_r, 12'h000, active_sync_source};
        `SCS_A_DEV: prdata <= {{8{fdev_r[7]}}, fdev_r, dev_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // scs_sync_core
`default_nettype wire

// File: rtl/scs_regs.vh
`ifndef SCS_REGS_VH
`define SCS_REGS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define SCS_CLK_HZ 50000000
`define SCS_MS_PER_S 1000
// cycles per millisecond of the time base
`define SCS_TICK_CYC (`SCS_CLK_HZ / `SCS_MS_PER_S)
// fallback time, tenths of a minute (1.5 min)
`define SCS_TMO_MIN_X10 15
`define SCS_TMO_S (`SCS_TMO_MIN_X10 * 60 / 10)
// ----------------------------------------
// millisecond figures, then interval limits in seconds
// ----------------------------------------
`define SCS_DAY_MS 34'h005265C00
`define SCS_HALF_DAY_MS 34'h002932E00
`define SCS_MIN_MS 34'h00000EA60
`define SCS_HALF_MIN_MS 34'h000007530
`define SCS_STEP_MS 34'h000000FA0
`define SCS_DEV_LIM 34'h000007FFF
`define SCS_FDEV_LIM 34'h00000007D
`define SCS_HOUR_MS 34'h00036EE80
`define SCS_ZONE_MS 34'h000008CA0
`define SCS_INTV_MAX 10'h3E8
`define SCS_INTV_HALF 10'h1F4
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SCS_A_CTRL 8'h00
`define SCS_A_TIME 8'h04
`define SCS_A_SYNC 8'h08
`define SCS_A_CODE 8'h0C
`define SCS_A_OFFS 8'h10
`define SCS_A_ZONE 8'h14
`define SCS_A_INTV 8'h18
`define SCS_A_STAT 8'h1C
`define SCS_A_DEV 8'h20
// control fields
`define SCS_C_SEL 1:0
`define SCS_C_POL1 2
`define SCS_C_POL2 3
`define SCS_C_VPULSE 4
`define SCS_C_DST 5
`define SCS_C_DRIFT 6
// minute pulse selector values
`define SCS_SEL_NONE 2'h0
`define SCS_SEL_ONE 2'h1
`define SCS_SEL_TWO 2'h2
`define SCS_SEL_VIRT 2'h3
// sync source codes
`define SCS_SRC_INT 4'h0
`define SCS_SRC_DI 4'h1
`define SCS_SRC_NTP 4'h2
`define SCS_SRC_SER 4'h3
`define SCS_SRC_MB 4'h4
`define SCS_SRC_MBTCP 4'h5
`define SCS_SRC_FBUS 4'h6
`define SCS_SRC_TC101 4'h7
`define SCS_SRC_TC103 4'h8
`define SCS_SRC_DNP 4'h9
`endif

// File: dv/scs_sync_core_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "scs_regs.vh"
module scs_sync_core_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and state
  input wire logic pulse_input_one,
  input wire logic pulse_input_two,
  input wire logic [26:0] time_ms,
  input wire logic [3:0] active_sync_source
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // access phase and the time and sync writes, which may move the clock or source
  wire logic acc = psel && penable;
  wire logic wr_time = acc && pwrite && paddr == `SCS_A_TIME;
  wire logic wr_sync = acc && pwrite && paddr == `SCS_A_SYNC;
  a_zero_wait: assert property (acc |-> pready) else $error("access without ready");
  a_err_unmapped: assert property (acc && paddr > `SCS_A_DEV |-> pslverr)
    else $error("unmapped access not refused");
  a_err_quiet: assert property (!acc |-> !pslverr) else $error("error outside access");
  a_err_rd_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_no_backstep: assert property (!$past(wr_time) |->
    !(time_ms < $past(time_ms) && $past(time_ms) - time_ms < 27'd4000))
    else $error("clock stepped back by a small amount");
  a_small_forward: assert property (!$past(wr_time) |->
    !(time_ms > $past(time_ms) + 27'd2 && time_ms - $past(time_ms) < 27'd4000))
    else $error("clock jumped forward by a small amount");
  a_day_range: assert property (time_ms < 27'd86400000)
    else $error("time beyond one day");
  a_src_codes: assert property (active_sync_source <= `SCS_SRC_DNP)
    else $error("unknown source code");
  a_src_cause: assert property ($changed(active_sync_source) &&
    active_sync_source > `SCS_SRC_DI |-> $past(wr_sync) || $past(wr_sync, 2))
    else $error("protocol source without message");
  a_reset_clear: assert property ($rose(nrst) |-> time_ms == 27'h0 && active_sync_source == 4'h0)
    else $error("state not cleared by reset");
endmodule // scs_sync_core_chk
bind scs_sync_core scs_sync_core_chk scs_sync_core_chk_inst (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_input_one(pulse_input_one),
  .pulse_input_two(pulse_input_two), .time_ms(time_ms), .active_sync_source(active_sync_source));
`default_nettype wire

// File: dv/scs_pulse_src.sv
`timescale 1ns/1ns
`default_nettype none
// external minute pulse master: one rising edge, then held high for HOLD cycles
module scs_pulse_src #(
  parameter int HOLD = 500
) (
  // clock and command
  input wire logic clk,
  input wire logic fire,
  // pulse pin, low when idle
  output logic pin
);
  int cnt = 0; // cycles of pulse left
  // start a pulse and hold it for the full span
  always @(posedge clk) begin
    if (fire && cnt == 0) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign pin = (cnt > 0);
endmodule // scs_pulse_src
`default_nettype wire

// File: dv/system_clock_sync_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "scs_regs.vh"
module system_clock_sync_bench;
  localparam int TK = 10; // cycles per ms
  localparam int HD = 50 * TK; // 50 ms pulse
  localparam int ZH = 150 * 36000 + 3600000; // 1.5 h zone plus summer hour, ms
  logic fire2 = 1'b0; // pulse command for pin two
  int exp_q[$]; // expected status words, oldest first
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, seed = 32'h59FC3FC8;
  logic perr;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, p_one, p_two;
  wire logic [26:0] time_ms;
  wire logic [3:0] active_sync_source;
  int errors = 0, comparisons = 0, tm, cnt = 0, od = 0, dev, flt, dv, off, src;
  always #10 clk = ~clk;
  scs_sync_core #(.TICK_CYC(TK)) scs_sync_core_inst (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_input_one(p_one), .pulse_input_two(p_two),
    .time_ms(time_ms), .active_sync_source(active_sync_source));
  scs_pulse_src #(.HOLD(HD)) scs_pulse_src_inst (.clk(clk), .fire(fire), .pin(p_one));
  scs_pulse_src #(.HOLD(HD)) scs_pulse_src_two_inst (.clk(clk), .fire(fire2), .pin(p_two));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int lim(int x, int m);
    return x > m ? m : (x < -m ? -m : x);
  endfunction
  // one apb transfer; read data, error and time taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    tm = int'(time_ms);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one minute pulse on pin one or pin two
  task automatic pulse(input logic two);
    fire <= !two;
    fire2 <= two;
    @(posedge clk);
    fire <= 1'b0;
    fire2 <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    apb(0, `SCS_A_CODE, 0);
    chk(rd, 32'h2);
    apb(0, 8'h40, 0);
    chk({rd[30:0], perr}, 32'h1);
    apb(1, `SCS_A_STAT, 32'hFFFFFFFF);
    apb(0, `SCS_A_STAT, 0);
    chk(rd, 32'h0);
    apb(1, `SCS_A_TIME, 32'd1000000);
    // protocol messages with random offset and deviation, every code
    for (int c = 2; c < 10; c++) begin
      off = int'(xs() % 201) - 100;
      dv = int'(xs() % 401) - 200;
      apb(1, `SCS_A_OFFS, 32'(off));
      apb(1, `SCS_A_CODE, 32'(c));
      src = int'(time_ms) - dv - off;
      apb(1, `SCS_A_SYNC, 32'(src));
      cnt++;
      exp_q.push_back(cnt * 65536 + c);
      dev = lim(tm - src - off, 32767);
      flt = lim((dev + od) >>> 1, 125);
      od = dev;
      apb(0, `SCS_A_STAT, 0);
      chk(rd, 32'(exp_q.pop_front()));
      chk(32'(active_sync_source), 32'(c));
      apb(0, `SCS_A_DEV, 0);
      chk(rd, {16'(flt), 16'(dev)});
    end
    // network time: zone offset and summer hour are added to the source time
    apb(1, `SCS_A_TIME, 32'd20000000);
    apb(1, `SCS_A_ZONE, 32'd150);
    apb(1, `SCS_A_CTRL, 32'h20);
    apb(1, `SCS_A_CODE, 32'h2);
    src = int'(time_ms) - dv - off - ZH;
    apb(1, `SCS_A_SYNC, 32'(src));
    cnt++;
    dev = lim(tm - src - off - ZH, 32767);
    flt = lim((dev + od) >>> 1, 125);
    apb(0, `SCS_A_DEV, 0);
    chk(rd, {16'(flt), 16'(dev)});
    apb(0, `SCS_A_STAT, 0);
    chk(rd, 32'(cnt * 65536 + 2));
    // no pulse source selected: edges are ignored
    apb(1, `SCS_A_CTRL, 32'h0);
    pulse(1'b0);
    repeat (HD) @(posedge clk);
    apb(0, `SCS_A_STAT, 0);
    chk(32'(rd[31:16]), 32'(cnt));
    // pin one: clock 5 s ahead is set back to the minute
    apb(1, `SCS_A_TIME, 32'd125000);
    apb(1, `SCS_A_CTRL, 32'h1);
    pulse(1'b0);
    chk(32'(time_ms >= 27'd120000 && time_ms <= 27'd120001), 32'h1);
    repeat (HD) @(posedge clk);
    cnt++;
    apb(0, `SCS_A_STAT, 0);
    chk(rd, 32'(cnt * 65536 + 1));
    // pin two: clock 5 s behind moves up to the next minute
    apb(1, `SCS_A_TIME, 32'd175000);
    apb(1, `SCS_A_CTRL, 32'h2);
    pulse(1'b1);
    chk(32'(time_ms >= 27'd180000 && time_ms <= 27'd180001), 32'h1);
    repeat (HD) @(posedge clk);
    cnt++;
    apb(0, `SCS_A_STAT, 0);
    chk(rd, 32'(cnt * 65536 + 1));
    // virtual pulse strobe once the virtual source is selected
    apb(1, `SCS_A_TIME, 32'd244000);
    apb(1, `SCS_A_CTRL, 32'h3);
    apb(1, `SCS_A_CTRL, 32'h13);
    repeat (2) @(posedge clk);
    chk(32'(time_ms >= 27'd240000 && time_ms <= 27'd240001), 32'h1);
    cnt++;
    apb(0, `SCS_A_STAT, 0);
    chk(rd, 32'(cnt * 65536 + 1));
    complete_run();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule // system_clock_sync_bench
`default_nettype wire
